// ===== hdl/ivm_idx_if.sv
// Purpose: Carries one group of flags and its encoded index
// Assumes: Single clock domain
// Notes: Used between the mapper and its priority encoder
`timescale 1ns/1ps
`default_nettype none
interface ivm_idx_if #(parameter int N = 16);
    logic [N-1:0] flags;
    logic [4:0] index;
    logic any;
    modport enc (input flags, output index, output any);
    modport user (output flags, input index, input any);
endinterface : ivm_idx_if
`default_nettype wire

// ===== hdl/ivm_map.svh
// Purpose: Constants for the interrupt vector mapper
// Assumes: Word addresses are 16-bit byte addresses of vector words
// Notes: Guarded header, definitions only
`ifndef IVM_MAP_SVH
`define IVM_MAP_SVH
`define IVM_VEC_A3 16'hffbe
`define IVM_VEC_A2 16'hffc0
`define IVM_VEC_B1 16'hffbc
`define IVM_VEC_RTC 16'hffcc
`define IVM_VEC_ACC 16'hffb4
`define IVM_VEC_PSV 16'hffb2
`define IVM_VEC_PLL 16'hffb0
`define IVM_VEC_PHY 16'hffae
`define IVM_VEC_ADC 16'hffac
`define IVM_VEC_NONE 16'h0000
`define IVM_PERIPH_LO 16'h0000
`define IVM_PERIPH_HI 16'h0fff
`define IVM_RESET_CYCLES 4'h4
`endif

// ===== hdl/ivm_mapper.sv
// Purpose: Maps peripheral flags onto vector word addresses
// Assumes: Flags are level inputs, synchronous to clk, each with its own enable
// Notes: One request to the core at a time, highest address first
`timescale 1ns/1ps
`include "ivm_map.svh"
`default_nettype none
module ivm_mapper
    import ivm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic gie,
    input wire logic [5:0] rtc_flags,
    input wire logic [5:0] rtc_en,
    input wire logic [3:0] serial_a2_flags,
    input wire logic [3:0] serial_a2_en,
    input wire logic serial_a2_uart,
    input wire logic [3:0] serial_a3_flags,
    input wire logic [3:0] serial_a3_en,
    input wire logic serial_a3_uart,
    input wire logic [13:0] serial_b1_flags,
    input wire logic [13:0] serial_b1_en,
    input wire logic serial_b1_i2c,
    input wire logic [4:0] acc_flags,
    input wire logic [4:0] acc_en,
    input wire logic [1:0] psv_flags,
    input wire logic [1:0] psv_en,
    input wire logic pll_flag,
    input wire logic pll_en,
    input wire logic [3:0] phy_flags,
    input wire logic [3:0] phy_en,
    input wire logic [5:0] adc_flags,
    input wire logic [5:0] adc_en,
    input wire logic [8:0] nmi_sel,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [4:0] rtc_vector_index,
    output logic [4:0] serial_a2_vector_index,
    output logic [4:0] serial_a3_vector_index,
    output logic [4:0] serial_b1_vector_index,
    output logic [4:0] accelerator_vector_index,
    output logic [4:0] psv_index,
    output logic [4:0] pll_index,
    output logic [4:0] interrupt_index_reg,
    output logic [4:0] adc_index,
    output logic periph_fetch_reset
);
    ////////////////////////////////////////////////////////////////////////
    // Per-source gating and encoding
    ivm_idx_if #(.N(6)) rtc_if ();
    ivm_idx_if #(.N(4)) a2_if ();
    ivm_idx_if #(.N(4)) a3_if ();
    ivm_idx_if #(.N(14)) b1_if ();
    ivm_idx_if #(.N(5)) acc_if ();
    ivm_idx_if #(.N(2)) psv_if ();
    ivm_idx_if #(.N(1)) pll_if ();
    ivm_idx_if #(.N(4)) phy_if ();
    ivm_idx_if #(.N(6)) adc_if ();

    // Individual enables gate every flag before encoding
    // Masked flags never reach an encoder, so indexes ignore them too
    assign rtc_if.flags = rtc_flags & rtc_en;
    // SPI mode keeps only receive and transmit (bits 0,1)
    assign a2_if.flags = serial_a2_flags & serial_a2_en
                         & {serial_a2_uart, serial_a2_uart, 2'b11};
    assign a3_if.flags = serial_a3_flags & serial_a3_en
                         & {serial_a3_uart, serial_a3_uart, 2'b11};
    // Outside I2C mode only bits 0,1 (receive/transmit) count
    assign b1_if.flags = serial_b1_flags & serial_b1_en
                         & {{12{serial_b1_i2c}}, 2'b11};
    assign acc_if.flags = acc_flags & acc_en;
    assign psv_if.flags = psv_flags & psv_en;
    assign pll_if.flags = pll_flag & pll_en;
    assign phy_if.flags = phy_flags & phy_en;
    assign adc_if.flags = adc_flags & adc_en;

    // One registered encoder per vector, the single-flag PLL included
    ivm_prio_enc #(.N(6)) u_rtc (.clk(clk), .rst_b(rst_b), .bus(rtc_if));
    ivm_prio_enc #(.N(4)) u_a2 (.clk(clk), .rst_b(rst_b), .bus(a2_if));
    ivm_prio_enc #(.N(4)) u_a3 (.clk(clk), .rst_b(rst_b), .bus(a3_if));
    ivm_prio_enc #(.N(14)) u_b1 (.clk(clk), .rst_b(rst_b), .bus(b1_if));
    ivm_prio_enc #(.N(5)) u_acc (.clk(clk), .rst_b(rst_b), .bus(acc_if));
    ivm_prio_enc #(.N(2)) u_psv (.clk(clk), .rst_b(rst_b), .bus(psv_if));
    ivm_prio_enc #(.N(1)) u_pll (.clk(clk), .rst_b(rst_b), .bus(pll_if));
    ivm_prio_enc #(.N(4)) u_phy (.clk(clk), .rst_b(rst_b), .bus(phy_if));
    ivm_prio_enc #(.N(6)) u_adc (.clk(clk), .rst_b(rst_b), .bus(adc_if));

    // Index outputs come straight from encoder flip-flops
    // Only the PHY group keeps the generic index name
    assign rtc_vector_index = rtc_if.index;
    assign serial_a2_vector_index = a2_if.index;
    assign serial_a3_vector_index = a3_if.index;
    assign serial_b1_vector_index = b1_if.index;
    assign accelerator_vector_index = acc_if.index;
    assign psv_index = psv_if.index;
    assign pll_index = pll_if.index;
    assign interrupt_index_reg = phy_if.index;
    assign adc_index = adc_if.index;

    ////////////////////////////////////////////////////////////////////////
    // Vector arbitration
    logic [IVM_NSRC-1:0] pend;
    logic [IVM_NSRC-1:0] take;
    // Bit order of pend matches the source enum and nmi_sel
    assign pend = {adc_if.any, phy_if.any, pll_if.any, psv_if.any, acc_if.any,
                   b1_if.any, a3_if.any, a2_if.any, rtc_if.any};

    // Global enable only holds off maskable sources
    // A nonmaskable source still needs its own enable, applied above
    genvar g;
    generate
        for (g = 0; g < IVM_NSRC; g++) begin : g_take
            assign take[g] = pend[g] & (gie | nmi_sel[g]);
        end
    endgenerate

    logic [15:0] vec_d;
    logic req_d;
    // Fixed order, highest word address first; ADC falls through last
    // A chain is deeper than a tree, but nine sources keep it short
    always_comb begin
        vec_d = `IVM_VEC_NONE;
        req_d = 1'b1;
        if (take[IVM_SRC_RTC]) begin
            vec_d = `IVM_VEC_RTC;
        end else if (take[IVM_SRC_A2]) begin
            vec_d = `IVM_VEC_A2;
        end else if (take[IVM_SRC_A3]) begin
            vec_d = `IVM_VEC_A3;
        end else if (take[IVM_SRC_B1]) begin
            vec_d = `IVM_VEC_B1;
        end else if (take[IVM_SRC_ACC]) begin
            vec_d = `IVM_VEC_ACC;
        end else if (take[IVM_SRC_PSV]) begin
            vec_d = `IVM_VEC_PSV;
        end else if (take[IVM_SRC_PLL]) begin
            vec_d = `IVM_VEC_PLL;
        end else if (take[IVM_SRC_PHY]) begin
            vec_d = `IVM_VEC_PHY;
        end else if (take[IVM_SRC_ADC]) begin
            vec_d = `IVM_VEC_ADC;
        end else begin
            req_d = 1'b0;
        end
    end

    logic irq_req_q;
    logic [15:0] irq_vector_q;
    // Request level follows pending sources; core clears at source
    // Vector and request move together, so the core never sees a stale pair
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_req_q <= 1'b0;
            irq_vector_q <= `IVM_VEC_NONE;
        end else begin
            irq_req_q <= req_d;
            irq_vector_q <= vec_d;
        end
    end
    assign irq_req = irq_req_q;
    assign irq_vector = irq_vector_q;

    ////////////////////////////////////////////////////////////////////////
    // Illegal fetch reset
    ivm_state_t st_q;
    logic [3:0] rcnt_q;
    logic bad_fetch;
    // Lower bound kept so the peripheral window can move in the map
    assign bad_fetch = fetch_valid && fetch_addr >= `IVM_PERIPH_LO
                       && fetch_addr <= `IVM_PERIPH_HI;

    // Stretch the reset pulse so the core sees it for several cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= IVM_ST_RUN;
            rcnt_q <= 4'h0;
        end else begin
            case (st_q)
                IVM_ST_RUN: begin
                    if (bad_fetch) begin
                        st_q <= IVM_ST_RST;
                        rcnt_q <= `IVM_RESET_CYCLES - 4'h1;
                    end
                end
                // Further bad fetches during the stretch are ignored
                IVM_ST_RST: begin
                    if (rcnt_q == 4'h0) begin
                        st_q <= IVM_ST_RUN;
                    end else begin
                        rcnt_q <= rcnt_q - 4'h1;
                    end
                end
                default: begin
                    st_q <= IVM_ST_RUN;
                end
            endcase
        end
    end

    logic prst_q;
    // Registered so the reset output never glitches
    // High from the bad-fetch edge through the three edges after it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prst_q <= 1'b0;
        end else begin
            prst_q <= (st_q == IVM_ST_RUN) ? bad_fetch : (rcnt_q != 4'h0);
        end
    end
    assign periph_fetch_reset = prst_q;
endmodule : ivm_mapper
`default_nettype wire

// ===== hdl/ivm_pkg.sv
// Purpose: Types for the interrupt vector mapper
// Assumes: Constants come from ivm_map.svh
// Notes: Source order is priority order, highest first
package ivm_pkg;
    typedef enum logic [3:0] {
        IVM_SRC_RTC = 4'h0,
        IVM_SRC_A2 = 4'h1,
        IVM_SRC_A3 = 4'h2,
        IVM_SRC_B1 = 4'h3,
        IVM_SRC_ACC = 4'h4,
        IVM_SRC_PSV = 4'h5,
        IVM_SRC_PLL = 4'h6,
        IVM_SRC_PHY = 4'h7,
        IVM_SRC_ADC = 4'h8
    } ivm_src_t;
    localparam int IVM_NSRC = 9;
    typedef enum logic [1:0] {
        IVM_ST_RUN = 2'b00,
        IVM_ST_RST = 2'b01
    } ivm_state_t;
endpackage : ivm_pkg

// ===== hdl/ivm_prio_enc.sv
// Purpose: Registered priority encoder for one multi-source vector
// Assumes: Bit 0 is the highest-priority flag
// Notes: Index is 2*(bit+1), zero when none pending
`timescale 1ns/1ps
`default_nettype none
module ivm_prio_enc #(
    parameter int N = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    ivm_idx_if.enc bus
);
    // Five index bits hold 2*N only while N stays at fifteen or less
    if (N < 1 || N > 15) begin : g_bad_n
        $error("ivm_prio_enc: N out of range");
    end

    logic [4:0] idx_d;
    // Lowest set bit wins; loop runs from top so lowest overwrites
    always_comb begin
        idx_d = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (bus.flags[i]) begin
                idx_d = 5'((i + 1) * 2);
            end
        end
    end

    logic [4:0] idx_q;
    logic any_q;
    // Index registered so the vector register reads a stable value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q <= 5'h00;
            any_q <= 1'b0;
        end else begin
            idx_q <= idx_d;
            any_q <= |bus.flags;
        end
    end
    assign bus.index = idx_q;
    assign bus.any = any_q;
endmodule : ivm_prio_enc
`default_nettype wire

// ===== verification/ivm_core_model.sv
// Purpose: Core side that issues instruction fetches
// Assumes: One fetch is one cycle wide
// Notes: Idle address is the inverse of the last one
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model (
    input wire logic clk,
    output logic fetch_valid,
    output logic [15:0] fetch_addr
);
    // Idle bus at time zero
    initial begin
        fetch_valid = 1'b0;
        fetch_addr = 16'hffff;
    end
    // Stale address would hide a decode slip, so invert it
    task automatic fetch(input logic [15:0] a);
        @(negedge clk);
        fetch_valid = 1'b1;
        fetch_addr = a;
        @(negedge clk);
        fetch_valid = 1'b0;
        fetch_addr = ~a;
    endtask : fetch
endmodule : ivm_core_model
`default_nettype wire

// ===== verification/ivm_mapper_bench.sv
// Purpose: Self-checking bench for the vector mapper
// Assumes: Fixed latencies, inputs move on the falling edge
// Notes: All flag groups packed into one vector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module ivm_mapper_bench;
    localparam int LO[10] = '{0, 6, 10, 14, 28, 33, 35, 36, 40, 46};
    localparam logic [15:0] VEC[9] = '{16'hffcc, 16'hffc0, 16'hffbe, 16'hffbc,
        16'hffb4, 16'hffb2, 16'hffb0, 16'hffae, 16'hffac};
    logic clk, rst_b, gie, a2_uart, a3_uart, b1_i2c, fv, irq_req, pfr;
    logic [45:0] fl, fe;
    logic [8:0] nmi_sel;
    logic [15:0] fa, irq_vector;
    logic [4:0] i_rtc, i_a2, i_a3, i_b1, i_acc, i_psv, i_pll, i_phy, i_adc;
    int fails, total_checks, cycles;
    ////////////////////////////////////////
    ivm_mapper dut (.clk, .rst_b, .gie, .rtc_flags(fl[5:0]), .rtc_en(fe[5:0]),
        .serial_a2_flags(fl[9:6]), .serial_a2_en(fe[9:6]), .serial_a2_uart(a2_uart),
        .serial_a3_flags(fl[13:10]), .serial_a3_en(fe[13:10]), .serial_a3_uart(a3_uart),
        .serial_b1_flags(fl[27:14]), .serial_b1_en(fe[27:14]), .serial_b1_i2c(b1_i2c),
        .acc_flags(fl[32:28]), .acc_en(fe[32:28]), .psv_flags(fl[34:33]),
        .psv_en(fe[34:33]), .pll_flag(fl[35]), .pll_en(fe[35]), .phy_flags(fl[39:36]),
        .phy_en(fe[39:36]), .adc_flags(fl[45:40]), .adc_en(fe[45:40]), .nmi_sel,
        .fetch_valid(fv), .fetch_addr(fa), .irq_req, .irq_vector, .rtc_vector_index(i_rtc),
        .serial_a2_vector_index(i_a2), .serial_a3_vector_index(i_a3),
        .serial_b1_vector_index(i_b1),
        .accelerator_vector_index(i_acc), .psv_index(i_psv), .pll_index(i_pll),
        .interrupt_index_reg(i_phy), .adc_index(i_adc), .periph_fetch_reset(pfr));
    ivm_core_model core (.clk, .fetch_valid(fv), .fetch_addr(fa));
    ////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic clr;
        fl = '0;
        fe = '1;
        gie = 1'b1;
        nmi_sel = '0;
        a2_uart = 1'b1;
        a3_uart = 1'b1;
        b1_i2c = 1'b1;
    endtask : clr
    ////////////////////////////////////////
    // Add sources lowest first; the newest must always win
    task automatic t_prio;
        clr();
        for (int g = 8; g >= 0; g--) begin
            for (int i = LO[g]; i < LO[g+1]; i++) fl[i] = 1'b1;
            cyc(3);
            `CHK(irq_vector, VEC[g])
            `CHK(irq_req, 1'b1)
        end
        `CHK(i_adc, 5'h02)
    endtask : t_prio
    // Indexes name the top flag; masking rtc hands over
    task automatic t_index;
        clr();
        fl[42:41] = 2'b11;
        fl[39] = 1'b1;
        fl[2] = 1'b1;
        fl[32] = 1'b1;
        fl[34] = 1'b1;
        fl[35] = 1'b1;
        cyc(3);
        `CHK(i_psv, 5'h04)
        `CHK(i_pll, 5'h02)
        `CHK(i_adc, 5'h04)
        `CHK(i_phy, 5'h08)
        `CHK(i_rtc, 5'h06)
        `CHK(i_acc, 5'h0a)
        fe[2] = 1'b0;
        cyc(3);
        `CHK(i_rtc, 5'h00)
        `CHK(irq_vector, 16'hffb4)
    endtask : t_index
    // Mode-only flags count only in their own mode
    task automatic t_modes;
        clr();
        a2_uart = 1'b0;
        a3_uart = 1'b0;
        b1_i2c = 1'b0;
        fl[9:8] = 2'b11;
        fl[12] = 1'b1;
        fl[19] = 1'b1;
        cyc(3);
        `CHK(i_a2, 5'h00)
        `CHK(i_a3, 5'h00)
        `CHK(i_b1, 5'h00)
        `CHK(irq_req, 1'b0)
        a2_uart = 1'b1;
        a3_uart = 1'b1;
        b1_i2c = 1'b1;
        cyc(3);
        `CHK(i_a2, 5'h06)
        `CHK(i_a3, 5'h06)
        `CHK(i_b1, 5'h0c)
        `CHK(irq_vector, 16'hffc0)
    endtask : t_modes
    // Nonmaskable ignores gie but obeys its own enable
    task automatic t_nmi;
        clr();
        gie = 1'b0;
        fl[40] = 1'b1;
        fl[36] = 1'b1;
        cyc(3);
        `CHK(irq_req, 1'b0)
        nmi_sel = 9'h100;
        cyc(3);
        `CHK(irq_vector, 16'hffac)
        fe[40] = 1'b0;
        cyc(3);
        `CHK(irq_req, 1'b0)
    endtask : t_nmi
    // Peripheral fetch stretches reset four cycles
    task automatic t_fetch;
        core.fetch(16'h0100);
        cyc(1);
        `CHK(pfr, 1'b1)
        cyc(2);
        `CHK(pfr, 1'b1)
        cyc(1);
        `CHK(pfr, 1'b0)
        core.fetch(16'h1000);
        cyc(2);
        `CHK(pfr, 1'b0)
        core.fetch(16'h0fff);
        cyc(1);
        `CHK(pfr, 1'b1)
    endtask : t_fetch
    ////////////////////////////////////////
    // Main sequence
    initial begin
        rst_b = 1'b0;
        clr();
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        t_prio();
        t_index();
        t_modes();
        t_nmi();
        t_fetch();
        give_verdict();
    end
endmodule : ivm_mapper_bench
`default_nettype wire

// ===== verification/ivm_mapper_checker.sv
// Purpose: Port assertions for the vector mapper
// Assumes: Index one cycle, request two cycles after flags
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module ivm_mapper_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic gie,
    input wire logic [5:0] rtc_flags,
    input wire logic [5:0] rtc_en,
    input wire logic [3:0] serial_a2_flags,
    input wire logic [3:0] serial_a2_en,
    input wire logic serial_a2_uart,
    input wire logic [5:0] adc_flags,
    input wire logic [5:0] adc_en,
    input wire logic [8:0] nmi_sel,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [4:0] rtc_vector_index,
    input wire logic [4:0] serial_a2_vector_index,
    input wire logic [4:0] adc_index,
    input wire logic periph_fetch_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // Steps of a request and of a reset stretch
    sequence s_rtc_hot;
        (rtc_flags & rtc_en) != 6'h00 && gie ##1 gie;
    endsequence
    sequence s_stretch;
        periph_fetch_reset[*4] ##1 !periph_fetch_reset;
    endsequence
    a_adc_top_flag: assert property ((adc_flags & adc_en) == 6'h06 |=> adc_index == 5'h04)
        else $error("adc index wrong");
    a_rtc_idle_zero: assert property ((rtc_flags & rtc_en) == 6'h00 |=> rtc_vector_index == 5'h00)
        else $error("rtc index not clear");
    a_rtc_wins_all: assert property (s_rtc_hot |=> irq_req && irq_vector == 16'hffcc)
        else $error("rtc did not win");
    a_gie_blocks_all: assert property ((!gie && nmi_sel == 9'h000)[*3] |-> !irq_req)
        else $error("request with gie low");
    a_nmi_passes_adc: assert property ((!gie && nmi_sel == 9'h100
        && (adc_flags & adc_en) != 6'h00)[*3] |-> irq_req && irq_vector == 16'hffac)
        else $error("nonmaskable adc lost");
    a_a2_mode_gate: assert property (!serial_a2_uart
        && (serial_a2_flags & serial_a2_en & 4'h3) == 4'h0 |=> serial_a2_vector_index == 5'h00)
        else $error("a2 mode bits leaked");
    a_fetch_reset_len: assert property (fetch_valid && fetch_addr <= 16'h0fff
        && !periph_fetch_reset |=> s_stretch)
        else $error("fetch reset length wrong");
    a_reset_has_cause: assert property ($rose(periph_fetch_reset)
        |-> $past(fetch_valid) && $past(fetch_addr) <= 16'h0fff)
        else $error("fetch reset without cause");
endmodule : ivm_mapper_checker
bind ivm_mapper ivm_mapper_checker chk (.clk, .rst_b, .gie, .rtc_flags, .rtc_en,
    .serial_a2_flags, .serial_a2_en, .serial_a2_uart, .adc_flags, .adc_en, .nmi_sel,
    .fetch_valid, .fetch_addr, .irq_req, .irq_vector, .rtc_vector_index,
    .serial_a2_vector_index, .adc_index, .periph_fetch_reset);
`default_nettype wire
